/* File: include/scc_pkg.sv */
/*
  Shared constants for the smartcard coupler control logic: operating modes,
  clock selections, reset configuration and timing counts.
  Assumes a single 100 MHz system clock.
*/
package scc_pkg;

  typedef enum logic [2:0] {
    SCC_STANDBY,
    SCC_PROGRAM,
    SCC_ACTIVE,
    SCC_TRANSACT,
    SCC_IDLE
  } scc_mode_t;

  typedef enum logic [2:0] {
    SCC_SEQ_OFF,
    SCC_SEQ_VCC,
    SCC_SEQ_IO,
    SCC_SEQ_CLK,
    SCC_SEQ_AUX,
    SCC_SEQ_RST
  } scc_seq_t;

  // Clock select codes, {reset_line, io_line} as sampled while programming
  localparam logic [1:0] SCC_CLK_SYNC = 2'h0;
  localparam logic [1:0] SCC_CLK_DIV4 = 2'h1;
  localparam logic [1:0] SCC_CLK_DIV2 = 2'h3;
  localparam logic [1:0] SCC_CLK_DIV1 = 2'h2;

  // Configuration state 4 after reset: 5 V supply, synchronous clock
  localparam logic SCC_RST_SUPPLY_5V = 1'b1;
  localparam logic [1:0] SCC_RST_CLK_SEL = SCC_CLK_SYNC;

  localparam int SCC_CLK_PERIOD_NS = 10;
  localparam int SCC_DEBOUNCE_US = 50;
  localparam int SCC_DEBOUNCE_CYCLES = (SCC_DEBOUNCE_US * 1000) / SCC_CLK_PERIOD_NS;
  localparam int SCC_DEB_W = 13;
  localparam int SCC_SEQ_STEP_CYCLES = 16;
  localparam int SCC_SEQ_W = 5;

endpackage

/* File: verilog/scc_debounce.sv */
/*
  Debounce filter for the card contact: the output follows the input only
  after it has been stable for a full count.
  Assumes the input is already synchronous to mclk_in.
*/
`timescale 1ns/1ps
module scc_debounce #(
  parameter int COUNT = 5000,
  parameter int W = 13
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Filter
  input wire logic raw_in,
  output logic stable_out
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic stable_reg;
  logic stable_next;

  always_comb begin
    cnt_next = '0;
    stable_next = stable_reg;
    if (raw_in != stable_reg) begin
      if (cnt_reg == W'(COUNT - 1)) begin
        stable_next = raw_in;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      stable_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      stable_reg <= stable_next;
    end
  end

  assign stable_out = stable_reg;

endmodule

/* File: verilog/scc_coupler.sv */
/*
  Smartcard coupler control: programming of supply and card clock, status
  on the ready/mode line, operating modes, wake-up interrupt, card clock
  generation and card signal activation order.
  Assumes all host pins are synchronous to mclk_in; the async clock input
  is sampled as data, so card clock rates must be well below mclk_in.
*/
`timescale 1ns/1ps
module scc_coupler (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Host control
  input wire logic chip_select_n_in,
  input wire logic power_on_request_in,
  input wire logic host_reset_in,
  input wire logic ready_mode_line_in,
  output logic ready_mode_line_out,
  output logic ready_mode_line_oe_n_out,
  output logic int_n_out,
  // Host data, host to card only
  input wire logic host_io_in,
  output logic host_io_out,
  output logic host_io_oe_n_out,
  input wire logic host_aux8_in,
  output logic host_aux8_out,
  output logic host_aux8_oe_n_out,
  input wire logic host_aux4_in,
  output logic host_aux4_out,
  output logic host_aux4_oe_n_out,
  // Clocks
  input wire logic sync_clock_in,
  input wire logic async_clock_in,
  // Card side
  input wire logic card_detect_in,
  input wire logic card_contact_polarity_in,
  input wire logic supply_in_range_in,
  input wire logic converter_ok_in,
  output logic converter_enable_out,
  output logic supply_5v_sel_out,
  output logic card_clock_out,
  output logic card_reset_out,
  input wire logic card_serial_line_in,
  output logic card_serial_line_out,
  output logic card_serial_line_oe_n_out,
  input wire logic card_aux8_line_in,
  output logic card_aux8_line_out,
  output logic card_aux8_line_oe_n_out,
  input wire logic card_aux4_line_in,
  output logic card_aux4_line_out,
  output logic card_aux4_line_oe_n_out,
  // Status
  output scc_pkg::scc_mode_t mode_out
);

  // ----------------------------------------------------------------
  // Card detect and edges
  // ----------------------------------------------------------------
  logic card_raw;
  logic card_present;
  assign card_raw = card_detect_in ^ card_contact_polarity_in;

  scc_debounce #(
    .COUNT(scc_pkg::SCC_DEBOUNCE_CYCLES),
    .W(scc_pkg::SCC_DEB_W)
  ) u_deb (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .raw_in(card_raw),
    .stable_out(card_present)
  );

  logic cs_n_d_reg;
  logic pwr_d_reg;
  logic card_d_reg;
  logic cs_rise;
  logic cs_fall;
  logic pwr_rise;
  logic card_change;
  assign cs_rise = chip_select_n_in & ~cs_n_d_reg;
  assign cs_fall = ~chip_select_n_in & cs_n_d_reg;
  assign pwr_rise = power_on_request_in & ~pwr_d_reg;
  assign card_change = card_present ^ card_d_reg;

  // ----------------------------------------------------------------
  // Mode, configuration and interrupt
  // ----------------------------------------------------------------
  scc_pkg::scc_mode_t mode_reg, mode_next;
  logic supply_5v_reg, supply_5v_next;
  logic [1:0] clk_sel_reg, clk_sel_next;
  logic int_n_reg, int_n_next;
  logic powered;

  always_comb begin
    mode_next = mode_reg;
    supply_5v_next = supply_5v_reg;
    clk_sel_next = clk_sel_reg;
    int_n_next = int_n_reg;
    // Insert and extract both wake the host in standby; set wins over release
    if (card_change && mode_reg == scc_pkg::SCC_STANDBY) begin
      int_n_next = 1'b0;
    end else if (cs_rise || pwr_rise) begin
      int_n_next = 1'b1;
    end
    case (mode_reg)
      scc_pkg::SCC_STANDBY: begin
        if (cs_fall && !ready_mode_line_in) begin
          mode_next = scc_pkg::SCC_PROGRAM;
        end else if (!chip_select_n_in) begin
          mode_next = scc_pkg::SCC_ACTIVE;
        end
      end
      scc_pkg::SCC_PROGRAM: begin
        if (cs_rise) begin
          if (!ready_mode_line_in) begin
            supply_5v_next = power_on_request_in;
            clk_sel_next = {host_reset_in, host_io_in};
          end
          mode_next = scc_pkg::SCC_STANDBY;
        end
      end
      scc_pkg::SCC_ACTIVE: begin
        if (chip_select_n_in && !power_on_request_in) begin
          mode_next = scc_pkg::SCC_STANDBY;
        end else if (powered) begin
          mode_next = scc_pkg::SCC_TRANSACT;
        end
      end
      scc_pkg::SCC_TRANSACT, scc_pkg::SCC_IDLE: begin
        if (!powered) begin
          mode_next = scc_pkg::SCC_ACTIVE;
        end else if (chip_select_n_in) begin
          mode_next = scc_pkg::SCC_IDLE;
        end else begin
          mode_next = scc_pkg::SCC_TRANSACT;
        end
      end
      default: mode_next = scc_pkg::SCC_STANDBY;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_reg <= scc_pkg::SCC_STANDBY;
      supply_5v_reg <= scc_pkg::SCC_RST_SUPPLY_5V;
      clk_sel_reg <= scc_pkg::SCC_RST_CLK_SEL;
      int_n_reg <= 1'b1;
      cs_n_d_reg <= 1'b1;
      pwr_d_reg <= 1'b0;
      card_d_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      supply_5v_reg <= supply_5v_next;
      clk_sel_reg <= clk_sel_next;
      int_n_reg <= int_n_next;
      cs_n_d_reg <= chip_select_n_in;
      pwr_d_reg <= power_on_request_in;
      card_d_reg <= card_present;
    end
  end

  // ----------------------------------------------------------------
  // Power sequencer
  // ----------------------------------------------------------------
  // Power request only counts while selected; extraction or overload forces down
  scc_pkg::scc_seq_t seq_reg, seq_next;
  logic [scc_pkg::SCC_SEQ_W-1:0] step_reg, step_next;
  logic want_power_reg, want_power_next;

  always_comb begin
    want_power_next = want_power_reg;
    if (!chip_select_n_in && mode_reg != scc_pkg::SCC_PROGRAM) begin
      want_power_next = power_on_request_in;
    end
    if (!card_present || !converter_ok_in) begin
      want_power_next = 1'b0;
    end
    seq_next = seq_reg;
    step_next = '0;
    if (step_reg != scc_pkg::SCC_SEQ_W'(scc_pkg::SCC_SEQ_STEP_CYCLES - 1)) begin
      step_next = step_reg + scc_pkg::SCC_SEQ_W'(1);
    end else if (want_power_reg) begin
      case (seq_reg)
        scc_pkg::SCC_SEQ_OFF: seq_next = scc_pkg::SCC_SEQ_VCC;
        scc_pkg::SCC_SEQ_VCC: seq_next = supply_in_range_in ? scc_pkg::SCC_SEQ_IO
                                                            : scc_pkg::SCC_SEQ_VCC;
        scc_pkg::SCC_SEQ_IO: seq_next = scc_pkg::SCC_SEQ_CLK;
        scc_pkg::SCC_SEQ_CLK: seq_next = scc_pkg::SCC_SEQ_AUX;
        default: seq_next = scc_pkg::SCC_SEQ_RST;
      endcase
    end else begin
      case (seq_reg)
        scc_pkg::SCC_SEQ_RST: seq_next = scc_pkg::SCC_SEQ_AUX;
        scc_pkg::SCC_SEQ_AUX: seq_next = scc_pkg::SCC_SEQ_CLK;
        scc_pkg::SCC_SEQ_CLK: seq_next = scc_pkg::SCC_SEQ_IO;
        scc_pkg::SCC_SEQ_IO: seq_next = scc_pkg::SCC_SEQ_VCC;
        default: seq_next = scc_pkg::SCC_SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      seq_reg <= scc_pkg::SCC_SEQ_OFF;
      step_reg <= '0;
      want_power_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      step_reg <= step_next;
      want_power_reg <= want_power_next;
    end
  end

  assign powered = (seq_reg == scc_pkg::SCC_SEQ_RST);

  logic io_on;
  logic clk_on;
  logic aux_on;
  logic rst_on;
  assign io_on = seq_reg >= scc_pkg::SCC_SEQ_IO;
  assign clk_on = seq_reg >= scc_pkg::SCC_SEQ_CLK;
  assign aux_on = seq_reg >= scc_pkg::SCC_SEQ_AUX;
  assign rst_on = powered;

  // ----------------------------------------------------------------
  // Card clock generation
  // ----------------------------------------------------------------
  // Divided clocks come from a free-running counter on async edges
  logic async_d_reg;
  logic [1:0] div_reg, div_next;
  logic [1:0] cur_sel_reg, cur_sel_next;
  logic cclk_reg, cclk_next;
  logic clk_gate_reg, clk_gate_next;
  logic src_level;
  logic new_level;

  function automatic logic sel_level(input logic [1:0] sel, input logic sync_v,
                                     input logic async_v, input logic [1:0] div);
    case (sel)
      scc_pkg::SCC_CLK_SYNC: sel_level = sync_v;
      scc_pkg::SCC_CLK_DIV1: sel_level = async_v;
      scc_pkg::SCC_CLK_DIV2: sel_level = div[0];
      default: sel_level = div[1];
    endcase
  endfunction

  always_comb begin
    div_next = div_reg;
    if (async_clock_in && !async_d_reg) begin
      div_next = div_reg + 2'h1;
    end
    src_level = sel_level(cur_sel_reg, sync_clock_in, async_clock_in, div_next);
    new_level = sel_level(clk_sel_reg, sync_clock_in, async_clock_in, div_next);
    cur_sel_next = cur_sel_reg;
    // Hop only while both sources sit low so no short pulse escapes
    if (cur_sel_reg != clk_sel_reg && !src_level && !new_level && !cclk_reg) begin
      cur_sel_next = clk_sel_reg;
    end
    // Gate moves only in a low phase, so power steps never cut a pulse;
    // a source stuck high keeps the gate open until it falls
    clk_gate_next = clk_gate_reg;
    if (!src_level && !cclk_reg) begin
      clk_gate_next = clk_on;
    end
    cclk_next = clk_gate_reg & src_level;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      async_d_reg <= 1'b0;
      div_reg <= 2'h0;
      cur_sel_reg <= scc_pkg::SCC_RST_CLK_SEL;
      cclk_reg <= 1'b0;
      clk_gate_reg <= 1'b0;
    end else begin
      clk_gate_reg <= clk_gate_next;
      async_d_reg <= async_clock_in;
      div_reg <= div_next;
      cur_sel_reg <= cur_sel_next;
      cclk_reg <= cclk_next;
    end
  end

  // ----------------------------------------------------------------
  // Host status and card line translation
  // ----------------------------------------------------------------
  logic sel;
  // Line stays a host input until the select fall is decoded
  assign sel = !chip_select_n_in && mode_reg != scc_pkg::SCC_PROGRAM
               && mode_reg != scc_pkg::SCC_STANDBY;

  // Status drive only while selected outside programming
  assign ready_mode_line_oe_n_out = !sel;
  assign ready_mode_line_out = power_on_request_in ? converter_ok_in
                                                   : card_present;
  assign int_n_out = int_n_reg;
  assign converter_enable_out = seq_reg != scc_pkg::SCC_SEQ_OFF;
  assign supply_5v_sel_out = supply_5v_reg;
  assign card_clock_out = cclk_reg;
  assign card_reset_out = rst_on & host_reset_in;
  assign mode_out = mode_reg;

  // Host to card on serial and aux lines; card answers never reach host, host-side enables are tied off
  assign card_serial_line_out = io_on & host_io_in;
  assign card_serial_line_oe_n_out = !(io_on && sel);
  assign host_io_out = card_serial_line_in;
  assign host_io_oe_n_out = 1'b1;
  assign card_aux8_line_out = aux_on & host_aux8_in;
  assign card_aux8_line_oe_n_out = !(aux_on && sel);
  assign host_aux8_out = card_aux8_line_in;
  assign host_aux8_oe_n_out = 1'b1;
  assign card_aux4_line_out = aux_on & host_aux4_in;
  assign card_aux4_line_oe_n_out = !(aux_on && sel);
  assign host_aux4_out = card_aux4_line_in;
  assign host_aux4_oe_n_out = 1'b1;

endmodule

/* File: verification/scc_coupler_chk.sv */
/*
  Port-level checker for scc_coupler.
  Assumes one clock domain and a bind onto every scc_coupler instance.
*/
`timescale 1ns/1ps
module scc_coupler_chk (
  // Clock, reset and host lines
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic chip_select_n_in,
  input wire logic power_on_request_in,
  input wire logic ready_mode_line_in,
  input wire logic converter_ok_in,
  // Observed outputs
  input wire logic ready_mode_line_out,
  input wire logic ready_mode_line_oe_n_out,
  input wire logic int_n_out,
  input wire logic converter_enable_out,
  input wire logic supply_5v_sel_out,
  input wire logic card_clock_out,
  input wire logic card_reset_out,
  input wire logic card_serial_line_oe_n_out,
  input wire scc_pkg::scc_mode_t mode_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reset_state: assert property ($fell(rst_in) |-> supply_5v_sel_out && !converter_enable_out
    && mode_out == scc_pkg::SCC_STANDBY) else $error("bad state after reset");
  a_prog_enter: assert property ($fell(chip_select_n_in) && !ready_mode_line_in
    && mode_out == scc_pkg::SCC_STANDBY |-> ##[1:2] mode_out == scc_pkg::SCC_PROGRAM)
    else $error("programming not entered");
  a_latch_5v: assert property (mode_out == scc_pkg::SCC_PROGRAM && $rose(chip_select_n_in)
    && !ready_mode_line_in && power_on_request_in |-> ##[1:2] supply_5v_sel_out)
    else $error("5 V not latched");
  a_latch_3v: assert property (mode_out == scc_pkg::SCC_PROGRAM && $rose(chip_select_n_in)
    && !ready_mode_line_in && !power_on_request_in |-> ##[1:2] !supply_5v_sel_out)
    else $error("3 V not latched");
  a_refuse_keep: assert property (mode_out == scc_pkg::SCC_PROGRAM && $rose(chip_select_n_in)
    && ready_mode_line_in |=> $stable(supply_5v_sel_out)[*2]) else $error("supply changed");
  a_drive_select: assert property (!ready_mode_line_oe_n_out |-> !chip_select_n_in
    && mode_out != scc_pkg::SCC_PROGRAM) else $error("mode line driven while unselected");
  a_standby_quiet: assert property (mode_out == scc_pkg::SCC_STANDBY |-> ready_mode_line_oe_n_out)
    else $error("mode line driven in standby");
  a_status_conv: assert property (!ready_mode_line_oe_n_out && power_on_request_in
    |-> ready_mode_line_out == converter_ok_in) else $error("converter status wrong");
  a_standby_enter: assert property ($rose(chip_select_n_in) && !power_on_request_in
    && mode_out inside {scc_pkg::SCC_ACTIVE, scc_pkg::SCC_PROGRAM}
    |-> ##[1:2] mode_out == scc_pkg::SCC_STANDBY) else $error("standby not entered");
  a_int_standby: assert property ($fell(int_n_out) |-> $past(mode_out) == scc_pkg::SCC_STANDBY)
    else $error("interrupt outside standby");
  a_int_release: assert property (($rose(chip_select_n_in) || $rose(power_on_request_in))
    && !int_n_out |-> ##[1:2] int_n_out) else $error("interrupt not released");
  a_lines_off: assert property (!converter_enable_out |-> !card_reset_out && !card_clock_out
    && card_serial_line_oe_n_out) else $error("card line active without supply");
  a_clk_high: assert property ($rose(card_clock_out) |-> card_clock_out[*2])
    else $error("runt high pulse");
  a_clk_low: assert property ($fell(card_clock_out) |-> !card_clock_out[*2])
    else $error("runt low pulse");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_prog: cover property (mode_out == scc_pkg::SCC_PROGRAM);
  c_transact: cover property (mode_out == scc_pkg::SCC_TRANSACT);
  c_wake: cover property ($fell(int_n_out));
endmodule
bind scc_coupler scc_coupler_chk i_scc_coupler_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .chip_select_n_in(chip_select_n_in), .power_on_request_in(power_on_request_in),
  .ready_mode_line_in(ready_mode_line_in), .converter_ok_in(converter_ok_in),
  .ready_mode_line_out(ready_mode_line_out), .ready_mode_line_oe_n_out(ready_mode_line_oe_n_out),
  .int_n_out(int_n_out), .converter_enable_out(converter_enable_out),
  .supply_5v_sel_out(supply_5v_sel_out), .card_clock_out(card_clock_out),
  .card_reset_out(card_reset_out), .card_serial_line_oe_n_out(card_serial_line_oe_n_out),
  .mode_out(mode_out));

/* File: verification/scc_host.sv */
/*
  Host controller model: select, power request, programming lines.
  Assumes the bench resolves the ready/mode wire with a pull-up.
*/
`timescale 1ns/1ps
module scc_host (
  // Clock
  input wire logic mclk_in,
  // Host lines
  output logic chip_select_n_out,
  output logic power_on_request_out,
  output logic host_reset_out,
  output logic host_io_out,
  output logic host_aux8_out,
  output logic mode_force_low_out
);
  initial begin
    chip_select_n_out = 1'b1;
    power_on_request_out = 1'b0;
    host_reset_out = 1'b0;
    host_io_out = 1'b0;
    host_aux8_out = 1'b0;
    mode_force_low_out = 1'b0;
  end
  // Keeps the aux path busy
  always @(posedge mclk_in) begin
    host_aux8_out <= ~host_aux8_out;
  end
  // Only one coupler on the bench, so selecting it is always exclusive
  task automatic drive(input logic cs_n, input logic pwr);
    @(posedge mclk_in);
    chip_select_n_out <= cs_n;
    power_on_request_out <= pwr;
  endtask
  // Keep low at the closing edge to latch; release it to be refused
  task automatic prog(input logic [2:0] st, input logic keep);
    @(posedge mclk_in);
    mode_force_low_out <= 1'b1;
    @(posedge mclk_in);
    chip_select_n_out <= 1'b0;
    repeat (3) @(posedge mclk_in);
    {power_on_request_out, host_reset_out, host_io_out} <= st;
    mode_force_low_out <= keep;
    repeat (3) @(posedge mclk_in);
    chip_select_n_out <= 1'b1;
    repeat (3) @(posedge mclk_in);
    mode_force_low_out <= 1'b0;
    power_on_request_out <= 1'b0;
  endtask
endmodule

/* File: verification/tb_top.sv */
/*
  Testbench for scc_coupler: programming, status, wake-up, power cycles.
  Assumes scc_host drives the host lines and a pull-up on the mode wire.
*/
`timescale 1ns/1ps
module tb_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic card_detect_in = 1'b0;
  logic supply_in_range_in = 1'b0;
  logic converter_ok_in = 1'b1;
  logic sync_clock_in = 1'b0;
  logic async_clock_in = 1'b0;
  logic [2:0] ck_cnt = 3'h0;
  logic cs_n, pwr, hrst, hio, haux8, force_low;
  logic rdy_out, rdy_oe_n, int_n, conv_en, sup5, cclk, ser_oe_n, aux8, aux8_oe_n;
  scc_pkg::scc_mode_t mode;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int i, s;
  time t0;
  logic [1:0] sel_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int per_tab [4] = '{160, 320, 160, 80};
  // Released wire floats high through the pull-up
  wire logic rdy_wire = !rdy_oe_n ? rdy_out : !force_low;

  scc_host i_scc_host (.mclk_in(mclk_in), .chip_select_n_out(cs_n),
    .power_on_request_out(pwr), .host_reset_out(hrst), .host_io_out(hio),
    .host_aux8_out(haux8), .mode_force_low_out(force_low));
  scc_coupler i_scc_coupler (.mclk_in(mclk_in), .rst_in(rst_in), .chip_select_n_in(cs_n),
    .power_on_request_in(pwr), .host_reset_in(hrst), .ready_mode_line_in(rdy_wire),
    .ready_mode_line_out(rdy_out), .ready_mode_line_oe_n_out(rdy_oe_n), .int_n_out(int_n),
    .host_io_in(hio), .host_io_out(), .host_io_oe_n_out(), .host_aux8_in(haux8),
    .host_aux8_out(), .host_aux8_oe_n_out(), .host_aux4_in(1'b0), .host_aux4_out(),
    .host_aux4_oe_n_out(), .sync_clock_in(sync_clock_in), .async_clock_in(async_clock_in),
    .card_detect_in(card_detect_in), .card_contact_polarity_in(1'b0),
    .supply_in_range_in(supply_in_range_in), .converter_ok_in(converter_ok_in),
    .converter_enable_out(conv_en), .supply_5v_sel_out(sup5), .card_clock_out(cclk),
    .card_reset_out(), .card_serial_line_in(1'b0), .card_serial_line_out(),
    .card_serial_line_oe_n_out(ser_oe_n), .card_aux8_line_in(1'b0), .card_aux8_line_out(aux8),
    .card_aux8_line_oe_n_out(aux8_oe_n), .card_aux4_line_in(1'b0), .card_aux4_line_out(),
    .card_aux4_line_oe_n_out(), .mode_out(mode));

  initial forever #5 mclk_in = ~mclk_in;
  // Async source 80 ns, sync source 160 ns; supply settles a cycle after enable
  always @(posedge mclk_in) begin
    ck_cnt <= ck_cnt + 3'h1;
    if (ck_cnt[1:0] == 2'h3) async_clock_in <= ~async_clock_in;
    if (ck_cnt == 3'h7) sync_clock_in <= ~sync_clock_in;
    supply_in_range_in <= conv_en;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_conv_off();
    for (i = 0; i < 600 && conv_en !== 1'b0; i++) @(posedge mclk_in);
  endtask

  initial begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk({sup5, int_n, conv_en, mode}, {3'h6, scc_pkg::SCC_STANDBY});
    for (s = 0; s < 8; s++) begin
      i_scc_host.prog(s[2:0], 1'b1);
      chk(sup5, s[2]);
    end
    i_scc_host.prog(3'h0, 1'b0);
    chk(sup5, 1'b1);
    $display("programming test done");
    card_detect_in <= 1'b1;
    for (i = 0; i < 6000 && int_n !== 1'b0; i++) @(posedge mclk_in);
    chk({int_n, i >= 5000}, 2'h1);
    i_scc_host.drive(1'b0, 1'b0);
    repeat (2) @(posedge mclk_in);
    chk(rdy_wire, 1'b1);
    i_scc_host.drive(1'b1, 1'b0);
    repeat (3) @(posedge mclk_in);
    chk(int_n, 1'b1);
    $display("insertion test done");
    for (s = 0; s < 4; s++) begin
      i_scc_host.prog({1'b1, sel_tab[s]}, 1'b1);
      i_scc_host.drive(1'b0, 1'b1);
      for (i = 0; i < 600 && mode !== scc_pkg::SCC_TRANSACT; i++) @(posedge mclk_in);
      chk({mode, ser_oe_n}, {scc_pkg::SCC_TRANSACT, 1'b0});
      chk({aux8, aux8_oe_n}, {haux8, 1'b0});
      @(posedge cclk) t0 = $time;
      @(posedge cclk);
      chk(32'($time - t0), per_tab[s]);
      i_scc_host.drive(1'b0, 1'b0);
      wait_conv_off();
      chk({conv_en, mode}, {1'b0, scc_pkg::SCC_ACTIVE});
      i_scc_host.drive(1'b1, 1'b0);
      repeat (3) @(posedge mclk_in);
      chk(mode, scc_pkg::SCC_STANDBY);
    end
    $display("power cycle test done");
    i_scc_host.drive(1'b0, 1'b1);
    repeat (3) @(posedge mclk_in);
    chk(rdy_wire, 1'b1);
    converter_ok_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(rdy_wire, 1'b0);
    converter_ok_in <= 1'b1;
    i_scc_host.drive(1'b0, 1'b0);
    wait_conv_off();
    i_scc_host.drive(1'b1, 1'b0);
    card_detect_in <= 1'b0;
    for (i = 0; i < 6000 && int_n !== 1'b0; i++) @(posedge mclk_in);
    chk(int_n, 1'b0);
    i_scc_host.drive(1'b1, 1'b1);
    repeat (3) @(posedge mclk_in);
    chk(int_n, 1'b1);
    i_scc_host.drive(1'b0, 1'b0);
    repeat (2) @(posedge mclk_in);
    chk(rdy_wire, 1'b0);
    i_scc_host.drive(1'b1, 1'b0);
    $display("status and extraction test done");
    give_verdict();
  end
endmodule
